// ===== bench/adcpb_analog.sv
// Purpose: analog side of the converter and the world on the port B pins
// Assumes: pins are sampled on REF_CLK, no pull resistors on port B
// Notes: channels 12 and up are not inputs, so their sample wanders
`timescale 1ns/10ps
module adcpb_analog
(
  // clock
  input wire logic clk,
  // converter side
  input wire logic [4:0] channel,
  output logic [7:0] sample,
  // port b pins
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] port_in
);
  logic [7:0] noise_r;

  initial noise_r = 8'h5a;
  always @(posedge clk)
    noise_r <= ~noise_r;
  // fixed level per real channel so results are predictable
  assign sample = (channel < 5'h0c) ? {3'h5, channel} : noise_r;
  // a pin not driven by the port is held by the outside world
  assign port_in = (port_oe & port_out) | (~port_oe & ext_level);
endmodule : adcpb_analog

// ===== bench/testbench.sv
// Purpose: register level test of converter control and port B
// Assumes: zero wait AHB-Lite slave, channel level 8'ha0 + channel
// Notes: bounded waits; a global cycle ceiling ends a hang
`timescale 1ns/10ps
`include "adcpb_consts.svh"
module testbench;
  logic clk, rst, hsel, hwrite, hready, hresp, wait_m, stop_m, active, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [4:0] chan;
  logic [7:0] sample, pin_in, pin_out, pin_oe, ext;
  int mismatches, total_checks, cycles, n;

  adcpb_top i_adcpb_top (.REF_CLK(clk), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
    .HRDATA(hrdata), .WAIT_MODE(wait_m), .STOP_MODE(stop_m),
    .CONV_CHANNEL(chan), .CONV_SAMPLE_DATA(sample), .CONV_ACTIVE(active),
    .CONV_IRQ(irq), .PORTB_IN(pin_in), .PORTB_OUT(pin_out),
    .PORTB_OE(pin_oe));
  adcpb_analog i_adcpb_analog (.clk(clk), .channel(chan), .sample(sample),
    .port_out(pin_out), .port_oe(pin_oe), .ext_level(ext),
    .port_in(pin_in));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd[7:0], exp);
  endtask : rdchk

  // polls the status register; polling only reads, so the flag survives
  task automatic wait_flag;
    n = 0;
    do
    begin
      xfer(`ADCPB_ADDR_SC, 1'b0, 8'h00);
      n++;
    end
    while (rd[`ADCPB_SC_FLAG] !== 1'b1 && n < 100);
    chk({7'h0, rd[`ADCPB_SC_FLAG]}, 8'h01);
  endtask : wait_flag

  task automatic wait_for(input logic want_irq);
    n = 0;
    while ((want_irq ? irq : active) !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, want_irq ? irq : active}, 8'h01);
  endtask : wait_for

  task automatic conv_len(input logic [7:0] exp);
    wait_for(1'b0);
    n = 0;
    while (active === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    // each edge sees the level of the cycle before it, one per active cycle
    chk(8'(n), exp);
  endtask : conv_len
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wait_m = 1'b0;
    stop_m = 1'b0;
    ext = 8'h3c;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(`ADCPB_ADDR_SC, 8'h1f);
    rdchk(`ADCPB_ADDR_DIR, 8'h00);
    rdchk(`ADCPB_ADDR_CLK, 8'h00);
    chk(pin_oe, 8'h00);
    rdchk(`ADCPB_ADDR_PORT, 8'h3c);
    wr(`ADCPB_ADDR_PORT, 8'ha5);
    wr(`ADCPB_ADDR_DIR, 8'h0f);
    rdchk(`ADCPB_ADDR_PORT, 8'h35);
    chk(pin_oe, 8'h0f);
    chk(pin_out, 8'h05);
    wr(`ADCPB_ADDR_PORT, 8'h5a);
    rdchk(`ADCPB_ADDR_PORT, 8'h3a);
    wr(`ADCPB_ADDR_DIR, 8'hff);
    rdchk(`ADCPB_ADDR_PORT, 8'h5a);
    wr(32'h100, 8'hff);
    rdchk(32'h100, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    // single conversion, pin 2 taken over by the converter
    wr(`ADCPB_ADDR_SC, 8'h02);
    conv_len(8'd14);
    chk(pin_oe, 8'hfb);
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'ha2);
    rdchk(`ADCPB_ADDR_SC, 8'h02);
    repeat (40) @(posedge clk);
    rdchk(`ADCPB_ADDR_SC, 8'h02);
    // slower converter clock, port D channel
    wr(`ADCPB_ADDR_CLK, 8'h20);
    rdchk(`ADCPB_ADDR_CLK, 8'h20);
    wr(`ADCPB_ADDR_SC, 8'h0b);
    conv_len(8'd28);
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'hab);
    wr(`ADCPB_ADDR_SC, 8'h0b);
    wait_flag();
    wr(`ADCPB_ADDR_SC, 8'h0b);
    rdchk(`ADCPB_ADDR_SC, 8'h0b);
    wr(`ADCPB_ADDR_CLK, 8'h00);
    // interrupt mode while waiting
    wait_m <= 1'b1;
    wr(`ADCPB_ADDR_SC, 8'h43);
    wait_for(1'b1);
    rdchk(`ADCPB_ADDR_SC, 8'h43);
    rdchk(`ADCPB_ADDR_DATA, 8'ha3);
    chk({7'h0, irq}, 8'h00);
    wr(`ADCPB_ADDR_SC, 8'h43);
    wait_for(1'b1);
    wr(`ADCPB_ADDR_SC, 8'h03);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    wait_m <= 1'b0;
    // continuous conversion, then stop mode
    wr(`ADCPB_ADDR_SC, 8'h24);
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'ha4);
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'ha4);
    stop_m <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, active}, 8'h00);
    repeat (100) @(posedge clk);
    rdchk(`ADCPB_ADDR_SC, 8'h24);
    stop_m <= 1'b0;
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'ha4);
    wait_flag();
    rdchk(`ADCPB_ADDR_DATA, 8'ha4);
    // power down, then a second reset
    wr(`ADCPB_ADDR_SC, 8'h1f);
    repeat (3) @(posedge clk);
    chk({7'h0, active}, 8'h00);
    repeat (60) @(posedge clk);
    rdchk(`ADCPB_ADDR_SC, 8'h1f);
    chk(pin_oe, 8'hff);
    wr(`ADCPB_ADDR_SC, 8'h43);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(`ADCPB_ADDR_SC, 8'h1f);
    chk({7'h0, irq}, 8'h00);
    rdchk(`ADCPB_ADDR_DIR, 8'h00);
    wr(`ADCPB_ADDR_DIR, 8'hff);
    rdchk(`ADCPB_ADDR_PORT, 8'h5a);
    results();
  end

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end
endmodule : testbench

// ===== verilog/adcpb_consts.svh
// Purpose: offsets, field positions, reset values and counts
// Assumes: 32-bit AHB-Lite, each register one word, byte addr = 4 * index
// Notes: definitions only
`ifndef ADCPB_CONSTS_SVH
`define ADCPB_CONSTS_SVH
// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define ADCPB_IDX_PORT 12'h001
`define ADCPB_IDX_DIR 12'h005
`define ADCPB_IDX_SC 12'h03c
`define ADCPB_IDX_DATA 12'h03d
`define ADCPB_IDX_CLK 12'h03e
`define ADCPB_ADDR_PORT (`ADCPB_IDX_PORT << 2)
`define ADCPB_ADDR_DIR (`ADCPB_IDX_DIR << 2)
`define ADCPB_ADDR_SC (`ADCPB_IDX_SC << 2)
`define ADCPB_ADDR_DATA (`ADCPB_IDX_DATA << 2)
`define ADCPB_ADDR_CLK (`ADCPB_IDX_CLK << 2)
// ----------------------------------------------------------------
// fields, reset values, counts
// ----------------------------------------------------------------
`define ADCPB_SC_FLAG 7
`define ADCPB_SC_IEN 6
`define ADCPB_SC_CONT 5
`define ADCPB_CLK_LSB 5
`define ADCPB_CH_OFF 5'h1f
`define ADCPB_PB_CHANS 5'h08
`define ADCPB_NUM_CHANS 5'h0c
`define ADCPB_CONV_LAST 4'hd
`define ADCPB_DDR_RST 8'h00
`define ADCPB_CLK_RST 3'h0
`endif

// ===== verilog/adcpb_conv.sv
// Purpose: converter clock divider and conversion sequencer
// Assumes: start is a one-cycle pulse from the register file
// Notes: converter clock tick every 2**div_sel bus cycles
`timescale 1ns/10ps
`include "adcpb_consts.svh"
module adcpb_conv
  import adcpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic cont,
  input wire logic stop,
  input wire logic pwr_down,
  input wire logic [2:0] div_sel,
  // status
  output logic done,
  output logic busy
);
  adcpb_conv_t s_r;
  adcpb_conv_t s_nxt;
  logic [6:0] mask;
  logic tick;

  assign mask = 7'((8'h01 << div_sel) - 8'h01);
  assign tick = (s_r.pre & mask) == mask;
  assign done = s_r.done;
  assign busy = s_r.st == CS_CONV;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.pre = s_r.pre + 7'h01;
    case (s_r.st)
      CS_IDLE: s_nxt.st = CS_IDLE;
      CS_ARM:
      begin
        if (tick)
        begin
          s_nxt.st = CS_CONV;
          s_nxt.cnt = 4'h0;
        end
      end
      CS_CONV:
      begin
        if (tick)
        begin
          if (s_r.cnt == `ADCPB_CONV_LAST)
          begin
            s_nxt.done = 1'b1;
            s_nxt.cnt = 4'h0;
            s_nxt.st = cont ? CS_CONV : CS_IDLE;
          end
          else
            s_nxt.cnt = s_r.cnt + 4'h1;
        end
      end
      default: s_nxt.st = CS_IDLE;
    endcase
    // a fresh write restarts, discarding any conversion under way
    if (start)
      s_nxt.st = CS_ARM;
    if (pwr_down)
      s_nxt.st = CS_IDLE;
    // stop aborts but keeps the request armed, so it resumes on exit
    if (stop)
    begin
      s_nxt.done = 1'b0;
      s_nxt.cnt = 4'h0;
      if (s_nxt.st != CS_IDLE)
        s_nxt.st = CS_ARM;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '{pre: 7'h00, st: CS_IDLE, cnt: 4'h0, done: 1'b0};
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_conv_len;
    done |-> $past(s_r.cnt) == `ADCPB_CONV_LAST && $past(busy);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion ended at wrong count");

  property p_arm_start;
    s_r.st == CS_ARM && tick && !start && !stop && !pwr_down
      |=> s_r.st == CS_CONV;
  endproperty
  a_arm_start: assert property (p_arm_start)
    else $error("conversion did not start on converter tick");

  property p_single;
    done && !cont && !start && !stop |-> s_r.st == CS_IDLE;
  endproperty
  a_single: assert property (p_single)
    else $error("single conversion did not idle");

  c_cont: cover property (done && cont);
endmodule : adcpb_conv

// ===== verilog/adcpb_pkg.sv
// Purpose: types shared by the converter and port B logic
// Assumes: constants live in adcpb_consts.svh
// Notes: the converter and top modules keep their state in one struct, bar the port B latch
package adcpb_pkg;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_ARM = 2'b01,
    CS_CONV = 2'b10
  } adcpb_cstate_t;

  typedef struct packed {
    logic [6:0] pre;
    adcpb_cstate_t st;
    logic [3:0] cnt;
    logic done;
  } adcpb_conv_t;

  typedef struct packed {
    logic ien;
    logic cont;
    logic [4:0] chan;
    logic flag;
    logic irq;
    logic [7:0] result;
    logic [7:0] ddr;
    logic [2:0] clksel;
    logic start;
    logic ap_sel;
    logic ap_write;
    logic [11:0] ap_addr;
    logic [31:0] hrdata;
  } adcpb_top_t;
endpackage : adcpb_pkg

// ===== verilog/adcpb_top.sv
// Purpose: converter control, converter registers and port B pins
// Assumes: AHB-Lite single word transfers, pins synchronous to REF_CLK
// Notes: zero wait states; the analog side supplies the selected sample
//
// Functional notes
// - with interrupts enabled, every finished conversion raises the request
// - with interrupts disabled, completion flag sets per conversion, read-only
// - with interrupts enabled, completion flag always reads zero
// - flag clears on control write, data read, or reset
// - pending request clears on data read or control write
// - reset clears the interrupt enable
// - converter keeps running in wait mode; request can wake cpu
// - channel select all ones powers the converter down
// - entering stop mode aborts conversion and holds the converter armed
// - converter resumes once stop mode ends
// - input chosen from twelve channels on ports B and D
// - selected pin is converter input, overriding port direction and data
// - port B eight-bit data latch, untouched by reset
// - direction bit one drives the pin, zero leaves it input
// - reset clears all port B direction bits
// - port B read returns latch for outputs, pin for inputs
// - latch writes always land whatever the direction
// - a conversion takes fourteen converter clocks
// - control write starts conversion at the next converter clock edge
// - continuous mode converts repeatedly, overwriting the result
`timescale 1ns/10ps
`include "adcpb_consts.svh"
module adcpb_top
  import adcpb_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // system modes
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  // converter side
  output logic [4:0] CONV_CHANNEL,
  input wire logic [7:0] CONV_SAMPLE_DATA,
  output logic CONV_ACTIVE,
  output logic CONV_IRQ,
  // port b pins
  input wire logic [7:0] PORTB_IN,
  output logic [7:0] PORTB_OUT,
  output logic [7:0] PORTB_OE
);
  adcpb_top_t s_r;
  adcpb_top_t s_nxt;
  logic [7:0] port_b_latch_bits;
  logic [7:0] pin_override;
  logic [7:0] portb_read;
  logic [7:0] sc_read;
  logic conv_done;
  logic conv_busy;
  logic pwr_down;
  logic ap_take;
  logic wr_data_phase;
  logic wr_sc;
  logic wr_portb;
  logic rd_take;
  logic rd_data;
  logic rd_sc;
  logic clr_flags;
  logic [11:0] rd_addr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s_r.hrdata;
  assign ap_take = HSEL && HTRANS[1] && HREADY;
  assign rd_addr = HADDR[11:0];
  assign wr_data_phase = s_r.ap_sel && s_r.ap_write;
  assign wr_sc = wr_data_phase && s_r.ap_addr == `ADCPB_ADDR_SC;
  assign wr_portb = wr_data_phase && s_r.ap_addr == `ADCPB_ADDR_PORT;
  assign rd_take = ap_take && !HWRITE;
  assign rd_data = rd_take && rd_addr == `ADCPB_ADDR_DATA;
  assign rd_sc = rd_take && rd_addr == `ADCPB_ADDR_SC;
  assign clr_flags = wr_sc || rd_data;

  // ----------------------------------------------------------------
  // converter sequencer
  // ----------------------------------------------------------------
  assign pwr_down = s_r.chan == `ADCPB_CH_OFF;

  // wait mode is deliberately not an input here: converting continues
  adcpb_conv u_conv (
    .clk(REF_CLK),
    .rst(RST),
    .start(s_r.start),
    .cont(s_r.cont),
    .stop(STOP_MODE),
    .pwr_down(pwr_down),
    .div_sel(s_r.clksel),
    .done(conv_done),
    .busy(conv_busy)
  );

  assign CONV_CHANNEL = s_r.chan;
  assign CONV_ACTIVE = conv_busy;
  // the request itself is the wake source from wait mode
  assign CONV_IRQ = s_r.irq;

  // ----------------------------------------------------------------
  // port b pins
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      // selected analog channel takes the pin away from the port
      assign pin_override[gi] = !pwr_down && s_r.chan == 5'(gi);
      assign PORTB_OE[gi] = s_r.ddr[gi] && !pin_override[gi];
      // latch has no reset; masking holds the pin low while its driver is off
      assign PORTB_OUT[gi] = port_b_latch_bits[gi] && PORTB_OE[gi];
      assign portb_read[gi] = s_r.ddr[gi] ? port_b_latch_bits[gi]
                                          : PORTB_IN[gi];
    end
  endgenerate

  // no reset on purpose: contents survive a reset
  always_ff @(posedge REF_CLK)
  begin
    if (wr_portb)
      port_b_latch_bits <= HWDATA[7:0];
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.ap_sel = ap_take;
    s_nxt.ap_write = HWRITE;
    s_nxt.ap_addr = rd_addr;
    if (wr_data_phase)
    begin
      case (s_r.ap_addr)
        `ADCPB_ADDR_SC:
        begin
          s_nxt.ien = HWDATA[`ADCPB_SC_IEN];
          s_nxt.cont = HWDATA[`ADCPB_SC_CONT];
          s_nxt.chan = HWDATA[4:0];
          s_nxt.start = HWDATA[4:0] != `ADCPB_CH_OFF;
        end
        `ADCPB_ADDR_DIR: s_nxt.ddr = HWDATA[7:0];
        `ADCPB_ADDR_CLK: s_nxt.clksel = HWDATA[7:`ADCPB_CLK_LSB];
        default: s_nxt.ddr = s_r.ddr;
      endcase
    end
    if (clr_flags)
    begin
      s_nxt.flag = 1'b0;
      s_nxt.irq = 1'b0;
    end
    // completion after the clear so a same-cycle event is kept
    if (conv_done)
    begin
      s_nxt.result = CONV_SAMPLE_DATA;
      if (s_r.ien)
        s_nxt.irq = 1'b1;
      else
        s_nxt.flag = 1'b1;
    end
    if (rd_take)
    begin
      case (rd_addr)
        `ADCPB_ADDR_PORT: s_nxt.hrdata = {24'h000000, portb_read};
        `ADCPB_ADDR_DIR: s_nxt.hrdata = {24'h000000, s_nxt.ddr};
        `ADCPB_ADDR_SC: s_nxt.hrdata = {24'h000000, sc_read};
        `ADCPB_ADDR_DATA: s_nxt.hrdata = {24'h000000, s_r.result};
        `ADCPB_ADDR_CLK:
          s_nxt.hrdata = {24'h000000, s_nxt.clksel, 5'h00};
        default: s_nxt.hrdata = 32'h00000000;
      endcase
    end
  end

  // status byte: control fields after any write landing this cycle, flag before it
  always_comb
  begin
    sc_read = 8'h00;
    sc_read[`ADCPB_SC_FLAG] = s_r.flag && !s_nxt.ien;
    sc_read[`ADCPB_SC_IEN] = s_nxt.ien;
    sc_read[`ADCPB_SC_CONT] = s_nxt.cont;
    sc_read[4:0] = s_nxt.chan;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_r.ien <= 1'b0;
      s_r.cont <= 1'b0;
      s_r.chan <= `ADCPB_CH_OFF;
      s_r.flag <= 1'b0;
      s_r.irq <= 1'b0;
      s_r.result <= 8'h00;
      s_r.ddr <= `ADCPB_DDR_RST;
      s_r.clksel <= `ADCPB_CLK_RST;
      s_r.start <= 1'b0;
      s_r.ap_sel <= 1'b0;
      s_r.ap_write <= 1'b0;
      s_r.ap_addr <= 12'h000;
      s_r.hrdata <= 32'h00000000;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_irq_set;
    conv_done && s_r.ien |=> CONV_IRQ && !s_r.flag;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("enabled conversion did not raise request");

  property p_flag_set;
    conv_done && !s_r.ien |=> s_r.flag && !CONV_IRQ[*1];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("completion flag not set");

  property p_flag_hidden;
    rd_sc && s_r.ien && !wr_sc |=> !HRDATA[`ADCPB_SC_FLAG];
  endproperty
  a_flag_hidden: assert property (p_flag_hidden)
    else $error("completion flag visible with interrupts on");

  property p_clear;
    clr_flags && !conv_done |=> !s_r.flag && !CONV_IRQ;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag or request survived a clearing access");

  property p_irq_hold;
    CONV_IRQ && !clr_flags |=> CONV_IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without clearing access");

  property p_stop;
    STOP_MODE |=> !CONV_ACTIVE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("converter active in stop mode");

  property p_override;
    !pwr_down && s_r.chan < `ADCPB_PB_CHANS |-> !PORTB_OE[s_r.chan[2:0]];
  endproperty
  a_override: assert property (p_override)
    else $error("selected analog pin still driven");

  property p_dir;
    (PORTB_OE & ~s_r.ddr) == 8'h00;
  endproperty
  a_dir: assert property (p_dir)
    else $error("driver on for an input pin");

  // latch taken from the address cycle: a write may land on the same edge
  property p_portb_read;
    ap_take && !HWRITE && rd_addr == `ADCPB_ADDR_PORT
      |=> HRDATA[7:0] == (($past(s_r.ddr) & $past(port_b_latch_bits))
                         | (~$past(s_r.ddr) & $past(PORTB_IN)));
  endproperty
  a_portb_read: assert property (p_portb_read)
    else $error("port read mixes latch and pin wrongly");

  property p_latch_wr;
    wr_portb |=> port_b_latch_bits == $past(HWDATA[7:0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr)
    else $error("latch write lost");

  c_irq: cover property (conv_done && s_r.ien);
  c_poll: cover property (s_r.flag ##1 rd_data);
  c_stop_abort: cover property (CONV_ACTIVE ##1 STOP_MODE);
  c_override: cover property (!pwr_down && s_r.ddr[s_r.chan[2:0]]);
endmodule : adcpb_top
